// file: shared/cam_pkg.sv
package cam_pkg;

  // opcode map groups (high nibble); halt and wait are full opcodes
  localparam logic [3:0] OPC_BIT_BRANCH = 4'h0;
  localparam logic [3:0] OPC_BIT_SETCLR = 4'h1;
  localparam logic [3:0] OPC_RELATIVE   = 4'h2;
  localparam logic [3:0] OPC_IDX16      = 4'hD;
  localparam logic [3:0] OPC_IDX8       = 4'hE;
  localparam logic [7:0] OPC_HALT       = 8'h8E;
  localparam logic [7:0] OPC_WAIT       = 8'h8F;

  // field positions inside the opcode
  localparam int BIT_NUM_LSB = 1;
  localparam int POLARITY_POS = 0;

  // program counter advances
  localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;

  // memory map
  localparam logic [15:0] SELFCHECK_START = 16'h3F00;
  localparam logic [15:0] SELFCHECK_END   = 16'h3FDF;
  localparam logic [15:0] USER_MEM_START  = 16'h2000;
  localparam logic [15:0] USER_MEM_END    = 16'h3EFF;
  localparam logic [15:0] USER_START_DEF  = 16'h2000;

  // cycles after reset release in which the strap is caught
  localparam logic [1:0] MODE_SAMPLE_CYCLES = 2'h2;

  // reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // self-check report patterns on pins {hi, mid, lo}; 0 lights the lamp
  localparam logic [2:0] REPORT_BAD_IO  = 3'h6;
  localparam logic [2:0] REPORT_BAD_RAM = 3'h5;
  localparam logic [2:0] REPORT_BAD_ROM = 3'h4;
  localparam logic [2:0] REPORT_BAD_IRQ = 3'h3;
  localparam logic [2:0] REPORT_DARK    = 3'h7;

  typedef enum logic [1:0] {
    CAM_MODE_USER,
    CAM_MODE_SELFCHECK,
    CAM_MODE_BOOTSTRAP
  } cam_mode_t;

  typedef enum logic [2:0] {
    CAM_TEST_PASS,
    CAM_TEST_BAD_IO,
    CAM_TEST_BAD_RAM,
    CAM_TEST_BAD_ROM,
    CAM_TEST_BAD_IRQ
  } cam_test_t;

endpackage

// file: logic/cam_addr_ctrl.sv
// How it works
// - idx16 address is index plus two bytes, pc+3
// - low byte index+byte3, high byte2 plus carry
// - relative offset always in address, added to pc only when condition holds
// - taken branch pc+2+offset, untaken pc+2
// - bit set/clear: opcode bit, zero-page address
// - bit branch reads byte, tests coded bit/polarity
// - taken bit branch targets pc+3+offset
// - tested bit always copied into carry
// - halt acts as no-operation, mask untouched
// - wait stops cpu clock, peripherals keep running
// - wait clears interrupt mask, state kept
// - watchdog always on, resets even in wait
// - normal interrupt level at release gives user mode
// - mode pin sampled in the first cycle after reset, released in the second
// - self-check runs program from 3F00 endlessly
// - report pins: flashing pass, fixed fault patterns
// - programmable part: elevated pin plus one gives bootstrap
// - programmable part maps user memory 2000-3EFF
// - idx8 low index+byte, high carry, pc+2
`timescale 1ns/1ps
`default_nettype none

module cam_addr_ctrl #(
  parameter bit          PROGRAMMABLE = 1'b0,
  parameter logic [15:0] USER_START   = cam_pkg::USER_START_DEF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // instruction request
  input  wire logic        instr_valid_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic [7:0]  oper1_in,
  input  wire logic [7:0]  oper2_in,
  input  wire logic [7:0]  index_in,
  input  wire logic [15:0] pc_in,
  input  wire logic        branch_cond_in,
  // operand read for bit test
  input  wire logic        read_data_valid_in,
  input  wire logic [7:0]  read_data_in,
  // decode results
  output logic             busy_out,
  output logic             done_out,
  output logic             known_out,
  output logic             read_req_out,
  output logic [15:0]      effective_address_out,
  output logic [15:0]      next_pc_out,
  output logic             carry_we_out,
  output logic             carry_out,
  output logic             bit_write_out,
  output logic [2:0]       bit_num_out,
  output logic             bit_set_out,
  output logic             user_mem_hit_out,
  // low power and watchdog
  input  wire logic        irq_pending_in,
  input  wire logic        wdog_timeout_in,
  output logic             imask_clear_out,
  output logic             cpu_clock_run_out,
  output logic             periph_clock_run_out,
  output logic             irq_service_out,
  output logic             mcu_reset_out,
  // mode selection
  input  wire logic        irq_elevated_in,
  input  wire logic        mode_select_pin_in,
  output logic             mode_select_release_out,
  output logic             mode_valid_out,
  output logic [1:0]       mode_out,
  output logic [15:0]      start_address_out,
  // self-check report pins
  input  wire logic [2:0]  selftest_result_in,
  input  wire logic        flash_in,
  output logic             report_pin_hi_out,
  output logic             report_pin_hi_oe_out,
  output logic             report_pin_mid_out,
  output logic             report_pin_mid_oe_out,
  output logic             report_pin_lo_out,
  output logic             report_pin_lo_oe_out
);

  typedef enum logic [1:0] {
    CAM_ST_IDLE,
    CAM_ST_BIT_READ,
    CAM_ST_SLEEP
  } cam_state_t;

  cam_state_t        state_q;
  logic              busy_q;
  logic              done_q;
  logic              known_q;
  logic              read_req_q;
  logic [15:0]       ea_q;
  logic [15:0]       next_pc_q;
  logic              carry_we_q;
  logic              carry_q;
  logic              bit_write_q;
  logic [2:0]        bit_num_q;
  logic              bit_set_q;
  logic              user_hit_q;
  logic              imask_clr_q;
  logic              cpu_run_q;
  logic              irq_srv_q;
  logic              mcu_rst_q;
  logic [15:0]       pc_hold_q;
  logic [7:0]        off_hold_q;
  logic              pol_hold_q;
  logic [1:0]        samp_cnt_q;
  logic              strap_pin_q;
  logic              strap_irq_q;
  logic              mode_valid_q;
  logic              release_q;
  cam_pkg::cam_mode_t mode_q;
  logic [15:0]       start_q;
  logic [2:0]        report_q;
  logic [2:0]        report_oe_q;

  // combinational decode of the request
  logic              take;
  logic [8:0]        low_sum;
  logic [15:0]       sext1;
  logic [15:0]       sext_hold;
  logic              tested_bit;
  logic              btb_taken;
  logic [2:0]        pattern_d;

  assign take = (state_q == CAM_ST_IDLE) && cpu_run_q && mode_valid_q && instr_valid_in;
  assign sext1 = {{8{oper1_in[7]}}, oper1_in};
  assign sext_hold = {{8{off_hold_q[7]}}, off_hold_q};
  assign tested_bit = read_data_in[bit_num_q];
  assign btb_taken = (tested_bit == ~pol_hold_q);

  always_comb
  begin
    low_sum = 9'h000;
    if (opcode_in[7:4] == cam_pkg::OPC_IDX16)
    begin
      low_sum = {1'b0, index_in} + {1'b0, oper2_in};
    end
    else
    begin
      low_sum = {1'b0, index_in} + {1'b0, oper1_in};
    end
  end

  // instruction sequencing; watchdog reset overrides everything
  always_ff @(posedge clk_in)
  begin
    if (rst_in || wdog_timeout_in)
    begin
      state_q     <= CAM_ST_IDLE;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      known_q     <= 1'b0;
      read_req_q  <= 1'b0;
      ea_q        <= cam_pkg::ADDR_RESET;
      next_pc_q   <= cam_pkg::ADDR_RESET;
      carry_we_q  <= 1'b0;
      carry_q     <= 1'b0;
      bit_write_q <= 1'b0;
      bit_num_q   <= 3'h0;
      bit_set_q   <= 1'b0;
      imask_clr_q <= 1'b0;
      cpu_run_q   <= 1'b1;
      irq_srv_q   <= 1'b0;
      pc_hold_q   <= cam_pkg::ADDR_RESET;
      off_hold_q  <= cam_pkg::BYTE_RESET;
      pol_hold_q  <= 1'b0;
    end
    else
    begin
      done_q      <= 1'b0;
      carry_we_q  <= 1'b0;
      bit_write_q <= 1'b0;
      imask_clr_q <= 1'b0;
      irq_srv_q   <= 1'b0;
      unique case (state_q)
        CAM_ST_IDLE:
        begin
          if (take)
          begin
            known_q   <= 1'b1;
            done_q    <= 1'b1;
            next_pc_q <= pc_in + cam_pkg::PC_STEP_ONE;
            if (opcode_in[7:4] == cam_pkg::OPC_IDX16)
            begin
              ea_q      <= {oper1_in + {7'h00, low_sum[8]}, low_sum[7:0]};
              next_pc_q <= pc_in + cam_pkg::PC_STEP_THREE;
            end
            else if (opcode_in[7:4] == cam_pkg::OPC_IDX8)
            begin
              ea_q      <= {7'h00, low_sum};
              next_pc_q <= pc_in + cam_pkg::PC_STEP_TWO;
            end
            else if (opcode_in[7:4] == cam_pkg::OPC_RELATIVE)
            begin
              ea_q <= pc_in + cam_pkg::PC_STEP_TWO + sext1;
              if (branch_cond_in)
              begin
                next_pc_q <= pc_in + cam_pkg::PC_STEP_TWO + sext1;
              end
              else
              begin
                next_pc_q <= pc_in + cam_pkg::PC_STEP_TWO;
              end
            end
            else if (opcode_in[7:4] == cam_pkg::OPC_BIT_SETCLR)
            begin
              ea_q        <= {8'h00, oper1_in};
              next_pc_q   <= pc_in + cam_pkg::PC_STEP_TWO;
              bit_write_q <= 1'b1;
              bit_num_q   <= opcode_in[cam_pkg::BIT_NUM_LSB +: 3];
              bit_set_q   <= ~opcode_in[cam_pkg::POLARITY_POS];
            end
            else if (opcode_in[7:4] == cam_pkg::OPC_BIT_BRANCH)
            begin
              // result waits for the operand byte
              done_q     <= 1'b0;
              busy_q     <= 1'b1;
              read_req_q <= 1'b1;
              ea_q       <= {8'h00, oper1_in};
              bit_num_q  <= opcode_in[cam_pkg::BIT_NUM_LSB +: 3];
              pol_hold_q <= opcode_in[cam_pkg::POLARITY_POS];
              pc_hold_q  <= pc_in;
              off_hold_q <= oper2_in;
              state_q    <= CAM_ST_BIT_READ;
            end
            else if (opcode_in == cam_pkg::OPC_HALT)
            begin
              next_pc_q <= pc_in + cam_pkg::PC_STEP_ONE;
            end
            else if (opcode_in == cam_pkg::OPC_WAIT)
            begin
              // pc already points past the wait for resumption
              imask_clr_q <= 1'b1;
              cpu_run_q   <= 1'b0;
              busy_q      <= 1'b1;
              state_q     <= CAM_ST_SLEEP;
            end
            else
            begin
              known_q <= 1'b0;
            end
          end
        end
        CAM_ST_BIT_READ:
        begin
          if (read_data_valid_in)
          begin
            read_req_q <= 1'b0;
            busy_q     <= 1'b0;
            done_q     <= 1'b1;
            carry_we_q <= 1'b1;
            carry_q    <= tested_bit;
            if (btb_taken)
            begin
              next_pc_q <= pc_hold_q + cam_pkg::PC_STEP_THREE + sext_hold;
            end
            else
            begin
              next_pc_q <= pc_hold_q + cam_pkg::PC_STEP_THREE;
            end
            state_q <= CAM_ST_IDLE;
          end
        end
        CAM_ST_SLEEP:
        begin
          if (irq_pending_in)
          begin
            cpu_run_q <= 1'b1;
            irq_srv_q <= 1'b1;
            busy_q    <= 1'b0;
            state_q   <= CAM_ST_IDLE;
          end
        end
      endcase
    end
  end

  // watchdog has no enable: a timeout always becomes a reset pulse
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mcu_rst_q <= 1'b0;
    end
    else
    begin
      mcu_rst_q <= wdog_timeout_in;
    end
  end

  // user memory window decode on the formed address
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      user_hit_q <= 1'b0;
    end
    else
    begin
      user_hit_q <= PROGRAMMABLE && (ea_q >= cam_pkg::USER_MEM_START)
                    && (ea_q <= cam_pkg::USER_MEM_END);
    end
  end

  // strap capture after reset release; depends on host holding the pin
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      samp_cnt_q   <= 2'h0;
      strap_pin_q  <= 1'b0;
      strap_irq_q  <= 1'b0;
      mode_valid_q <= 1'b0;
      release_q    <= 1'b0;
      mode_q       <= cam_pkg::CAM_MODE_USER;
      start_q      <= cam_pkg::ADDR_RESET;
    end
    else if (samp_cnt_q != cam_pkg::MODE_SAMPLE_CYCLES)
    begin
      samp_cnt_q <= samp_cnt_q + 2'h1;
      if (samp_cnt_q == 2'h0)
      begin
        strap_pin_q <= mode_select_pin_in;
        strap_irq_q <= irq_elevated_in;
      end
      else
      begin
        mode_valid_q <= 1'b1;
        release_q    <= 1'b1;
        if (!strap_irq_q)
        begin
          mode_q  <= cam_pkg::CAM_MODE_USER;
          start_q <= USER_START;
        end
        else if (PROGRAMMABLE && strap_pin_q)
        begin
          mode_q  <= cam_pkg::CAM_MODE_BOOTSTRAP;
          start_q <= cam_pkg::SELFCHECK_START;
        end
        else if (!PROGRAMMABLE && strap_pin_q)
        begin
          mode_q  <= cam_pkg::CAM_MODE_SELFCHECK;
          start_q <= cam_pkg::SELFCHECK_START;
        end
        else
        begin
          mode_q  <= cam_pkg::CAM_MODE_USER;
          start_q <= USER_START;
        end
      end
    end
  end

  // report pattern; repetition of the test program is what makes it flash
  always_comb
  begin
    pattern_d = cam_pkg::REPORT_DARK;
    unique case (cam_pkg::cam_test_t'(selftest_result_in))
      cam_pkg::CAM_TEST_PASS:    pattern_d = flash_in ? 3'h0 : cam_pkg::REPORT_DARK;
      cam_pkg::CAM_TEST_BAD_IO:  pattern_d = cam_pkg::REPORT_BAD_IO;
      cam_pkg::CAM_TEST_BAD_RAM: pattern_d = cam_pkg::REPORT_BAD_RAM;
      cam_pkg::CAM_TEST_BAD_ROM: pattern_d = cam_pkg::REPORT_BAD_ROM;
      cam_pkg::CAM_TEST_BAD_IRQ: pattern_d = cam_pkg::REPORT_BAD_IRQ;
      default:          pattern_d = cam_pkg::REPORT_DARK;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_report
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          report_q[g]    <= 1'b1;
          report_oe_q[g] <= 1'b0;
        end
        else
        begin
          report_q[g]    <= pattern_d[g];
          report_oe_q[g] <= mode_valid_q && (mode_q == cam_pkg::CAM_MODE_SELFCHECK);
        end
      end
    end
  endgenerate

  assign busy_out                = busy_q;
  assign done_out                = done_q;
  assign known_out               = known_q;
  assign read_req_out            = read_req_q;
  assign effective_address_out   = ea_q;
  assign next_pc_out             = next_pc_q;
  assign carry_we_out            = carry_we_q;
  assign carry_out               = carry_q;
  assign bit_write_out           = bit_write_q;
  assign bit_num_out             = bit_num_q;
  assign bit_set_out             = bit_set_q;
  assign user_mem_hit_out        = user_hit_q;
  assign imask_clear_out         = imask_clr_q;
  assign cpu_clock_run_out       = cpu_run_q;
  // peripheral clocks are never gated here, so timers can wake the cpu
  assign periph_clock_run_out    = 1'b1;
  assign irq_service_out         = irq_srv_q;
  assign mcu_reset_out           = mcu_rst_q;
  assign mode_select_release_out = release_q;
  assign mode_valid_out          = mode_valid_q;
  assign mode_out                = mode_q;
  assign start_address_out       = start_q;
  assign report_pin_hi_out       = report_q[2];
  assign report_pin_hi_oe_out    = report_oe_q[2];
  assign report_pin_mid_out      = report_q[1];
  assign report_pin_mid_oe_out   = report_oe_q[1];
  assign report_pin_lo_out       = report_q[0];
  assign report_pin_lo_oe_out    = report_oe_q[0];

endmodule

`default_nettype wire

// file: bench/cam_addr_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cam_chk (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // requests
  input wire logic        instr_valid_in,
  input wire logic [7:0]  opcode_in,
  input wire logic [7:0]  oper1_in,
  input wire logic [7:0]  oper2_in,
  input wire logic [7:0]  index_in,
  input wire logic [15:0] pc_in,
  input wire logic        branch_cond_in,
  input wire logic        irq_pending_in,
  input wire logic        wdog_timeout_in,
  // results
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        read_req_out,
  input wire logic [15:0] effective_address_out,
  input wire logic [15:0] next_pc_out,
  input wire logic        imask_clear_out,
  input wire logic        cpu_clock_run_out,
  input wire logic        periph_clock_run_out,
  input wire logic        mcu_reset_out,
  input wire logic        mode_valid_out,
  input wire logic [1:0]  mode_out,
  input wire logic        mode_select_release_out
);
  logic        take;
  logic [15:0] rel_off;
  assign take = instr_valid_in & ~busy_out & cpu_clock_run_out & mode_valid_out;
  assign rel_off = {{8{oper1_in[7]}}, oper1_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_IDX16: assert property (take && opcode_in[7:4] == 4'hD |=> done_out && next_pc_out ==
    $past(pc_in) + 16'h0003 && effective_address_out ==
    {$past(oper1_in), $past(oper2_in)} + {8'h00, $past(index_in)}) else $error("idx16 wrong");
  AST_REL: assert property (take && opcode_in[7:4] == 4'h2 |=> done_out && next_pc_out ==
    $past(pc_in) + 16'h0002 + ($past(branch_cond_in) ? $past(rel_off) : 16'h0000))
    else $error("relative wrong");
  AST_BB_READ: assert property (take && opcode_in[7:4] == 4'h0 |=> read_req_out && busy_out
    && effective_address_out == {8'h00, $past(oper1_in)}) else $error("bit test read wrong");
  AST_HALT: assert property (take && opcode_in == cam_pkg::OPC_HALT |=> done_out
    && !imask_clear_out && cpu_clock_run_out && next_pc_out == $past(pc_in) + 16'h0001)
    else $error("halt wrong");
  AST_WAIT: assert property (take && opcode_in == cam_pkg::OPC_WAIT |=> imask_clear_out
    && busy_out && !cpu_clock_run_out && periph_clock_run_out) else $error("wait entry wrong");
  AST_SLEEP: assert property (!cpu_clock_run_out && !irq_pending_in && !wdog_timeout_in
    && !mcu_reset_out |=> !cpu_clock_run_out && periph_clock_run_out) else $error("woke early");
  AST_WDOG: assert property (wdog_timeout_in |=> mcu_reset_out) else $error("no reset");
  AST_MODE: assert property (mode_valid_out |=> mode_valid_out && $stable(mode_out)
    && mode_select_release_out) else $error("mode moved");
endmodule
bind cam_addr_ctrl cam_chk chk_u (.*);
`default_nettype wire

// file: bench/cam_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cam_mem_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // operand read port
  input  wire logic       req_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [3:0] lat_in,
  output logic            valid_out,
  output logic [7:0]      data_out
);
  logic [3:0] cnt_q;
  logic       fed_q;
  // lane churns between answers so a late sample never sees stale data
  always_ff @(posedge clk_in)
  begin
    valid_out <= 1'b0;
    data_out  <= rst_in ? 8'h00 : ~data_out;
    if (rst_in || !req_in)
    begin
      cnt_q <= 4'h0;
      fed_q <= 1'b0;
    end
    else if (!fed_q && cnt_q == lat_in)
    begin
      valid_out <= 1'b1;
      data_out  <= {addr_in[3:0], addr_in[7:4]} ^ 8'hA5;
      fed_q     <= 1'b1;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_in, rst_in, instr_valid_in, branch_cond_in, read_data_valid_in, flash_in;
  logic        irq_pending_in, wdog_timeout_in, irq_elevated_in, mode_select_pin_in;
  logic [7:0]  opcode_in, oper1_in, oper2_in, index_in, read_data_in;
  logic [15:0] pc_in, effective_address_out, next_pc_out, start_address_out, last_np;
  logic [2:0]  selftest_result_in, bit_num_out;
  logic [1:0]  mode_out;
  logic [3:0]  lat;
  logic        busy_out, done_out, known_out, read_req_out, carry_we_out, carry_out;
  logic        bit_write_out, bit_set_out, user_mem_hit_out, imask_clear_out;
  logic        cpu_clock_run_out, periph_clock_run_out, irq_service_out, mcu_reset_out;
  logic        mode_select_release_out, mode_valid_out, report_pin_hi_out, report_pin_hi_oe_out;
  logic        report_pin_mid_out, report_pin_mid_oe_out, report_pin_lo_out, report_pin_lo_oe_out;
  int          n_mismatch, checked, seed;
  logic [2:0]  rpt [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h0};
  logic [7:0]  tab [7] = '{8'h00, 8'h10, 8'h20, 8'hD0, 8'hE0, 8'h8E, 8'h90};

  logic [1:0]  mode2;
  logic [15:0] start2;
  logic        hit2;

  cam_addr_ctrl dut_u (.*);
  // programmable variant shares the stimulus; only its strap and window outputs are watched
  cam_addr_ctrl #(.PROGRAMMABLE(1'b1)) dut2_u (.clk_in, .rst_in, .instr_valid_in, .opcode_in,
    .oper1_in, .oper2_in, .index_in, .pc_in, .branch_cond_in, .read_data_valid_in, .read_data_in,
    .busy_out(), .done_out(), .known_out(), .read_req_out(), .effective_address_out(),
    .next_pc_out(), .carry_we_out(), .carry_out(), .bit_write_out(), .bit_num_out(),
    .bit_set_out(), .user_mem_hit_out(hit2), .irq_pending_in, .wdog_timeout_in,
    .imask_clear_out(), .cpu_clock_run_out(), .periph_clock_run_out(), .irq_service_out(),
    .mcu_reset_out(), .irq_elevated_in, .mode_select_pin_in, .mode_select_release_out(),
    .mode_valid_out(), .mode_out(mode2), .start_address_out(start2), .selftest_result_in,
    .flash_in, .report_pin_hi_out(), .report_pin_hi_oe_out(), .report_pin_mid_out(),
    .report_pin_mid_oe_out(), .report_pin_lo_out(), .report_pin_lo_oe_out());
  cam_mem_model mem_u (.clk_in, .rst_in, .req_in(read_req_out), .addr_in(effective_address_out[7:0]),
    .lat_in(lat), .valid_out(read_data_valid_in), .data_out(read_data_in));

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic e, input logic p);
    @(posedge clk_in);
    {rst_in, irq_elevated_in, mode_select_pin_in} <= {1'b1, e, p};
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    {irq_elevated_in, mode_select_pin_in} <= {1'b0, ~p};
    @(negedge clk_in);
  endtask

  task automatic sleep();
    @(posedge clk_in);
    {instr_valid_in, opcode_in} <= {1'b1, cam_pkg::OPC_WAIT};
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
    chk("wait", {imask_clear_out, cpu_clock_run_out, periph_clock_run_out}, 3'h5);
  endtask

  task automatic run_op(input logic [7:0] opc);
    logic [7:0]  o1, o2, x, d;
    logic [15:0] pc, rel;
    logic [31:0] r, e;
    logic [3:0]  lt;
    logic        cond, b, isb;
    int          k;
    r = $random(seed);
    {o1, o2, x, cond, lt} = r[28:0];
    r = $random(seed);
    pc = r[15:0];
    if (opc[3:0] == 4'h0)
      opc[3:0] = r[19:16];
    d = {o1[3:0], o1[7:4]} ^ 8'hA5;
    b = d[opc[3:1]];
    isb = opc[7:4] == 4'h1;
    rel = pc + 16'h0002 + {{8{o1[7]}}, o1};
    @(posedge clk_in);
    lat <= lt;
    {instr_valid_in, opcode_in, oper1_in, oper2_in, index_in, pc_in} <= {1'b1, opc, o1, o2, x, pc};
    branch_cond_in <= cond;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_in);
      k++;
    end
    while (done_out !== 1'b1 && k < 40);
    case (opc[7:4])
      4'h0: e = {8'h00, o1, pc + 16'h0003 + (b != opc[0] ? {{8{o2[7]}}, o2} : 16'h0000)};
      4'h1: e = {8'h00, o1, pc + 16'h0002};
      4'h2: e = {rel, cond ? rel : pc + 16'h0002};
      4'hD: e = {{o1, o2} + {8'h00, x}, pc + 16'h0003};
      4'hE: e = {{8'h00, x} + {8'h00, o1}, pc + 16'h0002};
      default: e = {16'h0000, pc + 16'h0001};
    endcase
    last_np = e[15:0];
    chk("done", {done_out, known_out}, {1'b1, opc[7:4] != 4'h9});
    chk("next_pc", next_pc_out, e[15:0]);
    if (opc[7:5] != 3'h4)
      chk("ea", effective_address_out, e[31:16]);
    chk("carry", {carry_we_out, carry_out & carry_we_out}, {~|opc[7:4], b & ~|opc[7:4]});
    chk("bit", {bit_write_out, bit_write_out ? {bit_num_out, bit_set_out} : 4'h0},
      isb ? {1'b1, opc[3:1], ~opc[0]} : 5'h00);
    chk("mask", {imask_clear_out, cpu_clock_run_out}, 2'h1);
    // window flag follows the address one cycle later
    @(negedge clk_in);
    if (opc[7:5] != 3'h4)
      chk("user_hit", {user_mem_hit_out, hit2}, {1'b0,
        e[31:16] >= cam_pkg::USER_MEM_START && e[31:16] <= cam_pkg::USER_MEM_END});
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // the tests need well under two thousand cycles; this is far beyond that
  initial
  begin
    #200us;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    seed = 83255;
    rst_in = 1'b1;
    {instr_valid_in, branch_cond_in, irq_pending_in, wdog_timeout_in, irq_elevated_in} = '0;
    {mode_select_pin_in, flash_in, opcode_in, oper1_in, oper2_in, index_in, pc_in} = '0;
    {selftest_result_in, lat} = '0;
    for (int i = 3; i >= 0; i--)
    begin
      do_reset(i[0], i[1]);
      chk("mode", mode_out, i == 3 ? cam_pkg::CAM_MODE_SELFCHECK : cam_pkg::CAM_MODE_USER);
      chk("start", start_address_out,
        i == 3 ? cam_pkg::SELFCHECK_START : cam_pkg::USER_START_DEF);
      chk("boot_mode", mode2,
        i == 3 ? cam_pkg::CAM_MODE_BOOTSTRAP : cam_pkg::CAM_MODE_USER);
      chk("boot_start", start2,
        i == 3 ? cam_pkg::SELFCHECK_START : cam_pkg::USER_START_DEF);
      chk("released", mode_select_release_out, 1'b1);
      chk("pin_oe", {report_pin_hi_oe_out, report_pin_mid_oe_out,
        report_pin_lo_oe_out}, i == 3 ? 3'h7 : 3'h0);
      for (int r = 0; r < 6 && i == 3; r++)
      begin
        @(posedge clk_in);
        selftest_result_in <= r == 5 ? 3'h0 : 3'(r);
        flash_in <= r == 5;
        repeat (3) @(negedge clk_in);
        chk("report", {report_pin_hi_out, report_pin_mid_out, report_pin_lo_out}, rpt[r]);
      end
      $display("test mode %0d done", i);
    end
    for (int n = 0; n < 140; n++)
      run_op(tab[n % 7]);
    $display("test decode done");
    sleep();
    @(posedge clk_in);
    {instr_valid_in, opcode_in} <= {1'b1, 8'hD0};
    repeat (4)
    begin
      @(negedge clk_in);
      chk("refused", done_out, 1'b0);
    end
    @(posedge clk_in);
    {instr_valid_in, irq_pending_in} <= 2'h1;
    for (int k = 0; k < 4 && cpu_clock_run_out !== 1'b1; k++)
      @(negedge clk_in);
    chk("wake", {cpu_clock_run_out, irq_service_out, busy_out}, 3'h6);
    chk("kept_pc", next_pc_out, last_np);
    @(posedge clk_in);
    irq_pending_in <= 1'b0;
    sleep();
    @(posedge clk_in);
    wdog_timeout_in <= 1'b1;
    @(posedge clk_in);
    wdog_timeout_in <= 1'b0;
    @(negedge clk_in);
    chk("wdog", {mcu_reset_out, cpu_clock_run_out, mode_out}, {2'h3, cam_pkg::CAM_MODE_USER});
    run_op(8'hD0);
    $display("test low power done");
    finish_test();
  end
endmodule
`default_nettype wire
